/* File: rtl/faer_pkg.sv */
/*
 * Constants for the fault, alarm and event recorder: register map, field
 * positions, reset values, store depths and timing.
 * Assumes a single 40 MHz clock domain and a 32-bit Avalon-MM register bus.
 */
package faer_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int FAULT_DEPTH = 20;
    localparam int ALARM_DEPTH = 5;
    localparam int EVENT_DEPTH = 200;
    localparam int REC_WORDS = 4;
    // Record word layout (index within a record).
    localparam logic [1:0] W_TIME = 2'h0;
    localparam logic [1:0] W_INFO = 2'h1;
    localparam logic [1:0] W_VAB = 2'h2;
    localparam logic [1:0] W_VCN = 2'h3;
    // Event kinds.
    localparam logic [1:0] EV_INPUT = 2'h0;
    localparam logic [1:0] EV_OUTPUT = 2'h1;
    localparam logic [1:0] EV_ALARM = 2'h2;
    localparam logic [1:0] EV_TRIP = 2'h3;
    // Alarm status bit positions.
    localparam int AB_FREQ0 = 13;
    // Breaker timing sits apart from the stage flags so every stage keeps a flag of its own.
    localparam int AB_BRK_TIME = 22;
    localparam int AB_HW_WARN = 20;
    localparam int AB_BRK_POS = 21;
    localparam int AB_BRK_FAULTY = 24;
    localparam int AB_AUX_FAIL = 0;
    localparam int ALARM_BITS = 32;
    // Register byte addresses.
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_COUNTS = 12'h008;
    localparam logic [11:0] A_TIME = 12'h00C;
    localparam logic [11:0] A_SEL = 12'h010;
    localparam logic [11:0] A_DATA = 12'h014;
    localparam logic [11:0] A_TIME_SET = 12'h018;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] SEL_FAULT = 2'h0;
    localparam logic [1:0] SEL_ALARM = 2'h1;
    localparam logic [1:0] SEL_EVENT = 2'h2;
    localparam logic [31:0] UNMAPPED_VALUE = 32'hDEADBEEF;
    typedef enum logic [1:0] {FAER_IDLE, FAER_ACK} faer_bus_e;
endpackage : faer_pkg

/* File: rtl/faer_recorder.sv */
/*
 * Fault, alarm and event recorder with an Avalon-MM register slave.
 * Assumes protection algorithm inputs are synchronous to mclk, that a pass
 * strobe marks each algorithm run, and that the arrays map to non-volatile
 * storage in the target technology.
 */
`timescale 1ns/1ps
module faer_recorder
    import faer_pkg::*;
#(
    parameter int IN_BITS = 8,
    parameter int OUT_BITS = 8,
    parameter int MS_DIV = MS_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Protection algorithm
    input wire logic pass_stb,
    input wire logic fault_stb,
    input wire logic alarm_stb,
    input wire logic [4:0] cause_code,
    input wire logic [1:0] setting_group,
    input wire logic [3:0] phase_combo,
    input wire logic [15:0] v_a,
    input wire logic [15:0] v_b,
    input wire logic [15:0] v_c,
    input wire logic [15:0] residual_voltage,
    input wire logic [18:0] stage_alarm,
    input wire logic breaker_op_overtime,
    input wire logic hw_problem,
    input wire logic [1:0] breaker_pos,
    input wire logic breaker_problem_in,
    input wire logic aux_supply_fail,
    input wire logic [IN_BITS-1:0] bin_inputs,
    input wire logic [OUT_BITS-1:0] out_contacts,
    // Status
    output logic [31:0] alarm_status
);
    logic rst_meta, rst_sync;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    wire rst_n = rst_sync;

    // Stores: four words per record, two words per event.
    // No reset touches these arrays, so their contents outlive a restart of the logic.
    logic [31:0] fault_mem [FAULT_DEPTH*REC_WORDS];
    logic [31:0] alarm_mem [ALARM_DEPTH*REC_WORDS];
    logic [31:0] ev_mem [EVENT_DEPTH*2];

    function automatic logic [7:0] wrap_inc(input logic [7:0] p, input int depth);
        wrap_inc = (p == 8'(depth - 1)) ? 8'h00 : p + 8'h01;
    endfunction

    // Millisecond real time clock, settable by software.
    logic [31:0] ms_count_reg;
    logic [31:0] div_reg;
    wire ms_tick = (div_reg == 32'(MS_DIV - 1));
    wire time_wr;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 32'h0;
            ms_count_reg <= 32'h0;
        end else begin
            div_reg <= ms_tick ? 32'h0 : div_reg + 32'h1;
            if (time_wr)
                ms_count_reg <= avs_writedata;
            else if (ms_tick)
                ms_count_reg <= ms_count_reg + 32'h1;
        end
    end

    // Software control.
    logic latch_en_reg;
    logic [1:0] sel_kind_reg;
    logic [7:0] sel_idx_reg;
    logic [2:0] sel_word_reg;
    wire reset_cmd;

    // Alarm condition vector.
    wire brk_pos_bad = (breaker_pos == 2'b00) || (breaker_pos == 2'b11);
    logic [31:0] cond_now;
    always_comb begin
        cond_now = 32'h0;
        cond_now[AB_AUX_FAIL] = aux_supply_fail;
        cond_now[AB_FREQ0+6:1] = stage_alarm;
        cond_now[AB_BRK_TIME] = breaker_op_overtime;
        cond_now[AB_HW_WARN] = hw_problem;
        cond_now[AB_BRK_POS] = brk_pos_bad;
        cond_now[AB_BRK_FAULTY] = breaker_problem_in;
    end
    logic [31:0] cond_prev_reg;
    wire [31:0] status_next = latch_en_reg ?
        ((reset_cmd ? 32'h0 : alarm_status) | cond_now) : cond_now;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_status <= 32'h0;
        end else begin
            alarm_status <= status_next;
        end
    end

    // Alarm condition changes: lowest changed bit logged per cycle.
    wire [31:0] cond_chg = cond_now ^ cond_prev_reg;
    logic [4:0] chg_id;
    always_comb begin
        chg_id = 5'h0;
        for (int i = ALARM_BITS - 1; i >= 0; i--)
            if (cond_chg[i])
                chg_id = 5'(i);
    end

    // Input and output change tracking at each algorithm pass.
    logic [IN_BITS-1:0] in_prev_reg;
    logic [OUT_BITS-1:0] out_prev_reg;
    wire in_chg = pass_stb && (bin_inputs != in_prev_reg);
    wire out_chg = pass_stb && (out_contacts != out_prev_reg);
    logic out_pend_reg;

    // Event priority: trip, inputs, outputs, alarm change.
    // One store write per cycle keeps the event array single-ported; lower kinds wait.
    logic ev_we;
    logic [31:0] ev_word;
    always_comb begin
        ev_we = 1'b1;
        if (fault_stb)
            ev_word = {EV_TRIP, 9'h0, cause_code, v_a};
        else if (in_chg)
            ev_word = {EV_INPUT, 14'h0, 16'(bin_inputs)};
        else if (out_chg || out_pend_reg)
            ev_word = {EV_OUTPUT, 14'h0, 16'(out_contacts)};
        else if (|cond_chg)
            ev_word = {EV_ALARM, 23'h0, cond_now[chg_id], 1'b0, chg_id};
        else begin
            ev_we = 1'b0;
            ev_word = 32'h0;
        end
    end
    // A change not logged this cycle stays visible in prev so it is retried.
    wire take_in = in_chg && !fault_stb;
    wire take_out = (out_chg || out_pend_reg) && !fault_stb && !in_chg;
    wire take_cond = (|cond_chg) && !fault_stb && !in_chg && !(out_chg || out_pend_reg);

    logic [7:0] fault_wp_reg, alarm_wp_reg, ev_wp_reg;
    logic [7:0] fault_cnt_reg, alarm_cnt_reg, ev_cnt_reg;
    wire [31:0] info_word = {17'h0, cause_code, setting_group, phase_combo, 4'h0};
    always_ff @(posedge mclk) begin
        if (fault_stb) begin
            fault_mem[fault_wp_reg*4+W_TIME] <= ms_count_reg;
            fault_mem[fault_wp_reg*4+W_INFO] <= info_word;
            fault_mem[fault_wp_reg*4+W_VAB] <= {v_a, v_b};
            fault_mem[fault_wp_reg*4+W_VCN] <= {v_c, residual_voltage};
        end
        if (alarm_stb) begin
            alarm_mem[alarm_wp_reg*4+W_TIME] <= ms_count_reg;
            alarm_mem[alarm_wp_reg*4+W_INFO] <= info_word;
            alarm_mem[alarm_wp_reg*4+W_VAB] <= {v_a, v_b};
            alarm_mem[alarm_wp_reg*4+W_VCN] <= {v_c, residual_voltage};
        end
        if (ev_we && rst_n) begin
            ev_mem[ev_wp_reg*2] <= ms_count_reg;
            ev_mem[ev_wp_reg*2+1] <= ev_word;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_wp_reg <= 8'h0;
            alarm_wp_reg <= 8'h0;
            ev_wp_reg <= 8'h0;
            fault_cnt_reg <= 8'h0;
            alarm_cnt_reg <= 8'h0;
            ev_cnt_reg <= 8'h0;
            in_prev_reg <= '0;
            out_prev_reg <= '0;
            out_pend_reg <= 1'b0;
            cond_prev_reg <= 32'h0;
        end else begin
            if (fault_stb) begin
                fault_wp_reg <= wrap_inc(fault_wp_reg, FAULT_DEPTH);
                if (fault_cnt_reg != 8'(FAULT_DEPTH))
                    fault_cnt_reg <= fault_cnt_reg + 8'h1;
            end
            if (alarm_stb) begin
                alarm_wp_reg <= wrap_inc(alarm_wp_reg, ALARM_DEPTH);
                if (alarm_cnt_reg != 8'(ALARM_DEPTH))
                    alarm_cnt_reg <= alarm_cnt_reg + 8'h1;
            end
            if (ev_we) begin
                ev_wp_reg <= wrap_inc(ev_wp_reg, EVENT_DEPTH);
                if (ev_cnt_reg != 8'(EVENT_DEPTH))
                    ev_cnt_reg <= ev_cnt_reg + 8'h1;
            end
            if (take_in || (pass_stb && !in_chg))
                in_prev_reg <= bin_inputs;
            if (take_out)
                out_prev_reg <= out_contacts;
            out_pend_reg <= (out_chg || out_pend_reg) && !take_out;
            // Only the logged bit advances, so other changes of the same cycle are retried.
            if (take_cond)
                cond_prev_reg[chg_id] <= cond_now[chg_id];
        end
    end

    // Bus slave: one wait cycle, answer on the second edge.
    faer_bus_e bus_state_reg;
    wire req = avs_read || avs_write;
    wire hit_ctrl = (avs_address == A_CTRL);
    wire hit_status = (avs_address == A_STATUS);
    wire hit_counts = (avs_address == A_COUNTS);
    wire hit_time = (avs_address == A_TIME);
    wire hit_sel = (avs_address == A_SEL);
    wire hit_data = (avs_address == A_DATA);
    wire hit_tset = (avs_address == A_TIME_SET);
    wire do_wr = avs_write && (bus_state_reg == FAER_IDLE);
    assign time_wr = do_wr && hit_tset && (&avs_byteenable);
    assign reset_cmd = do_wr && hit_ctrl && avs_writedata[1];

    // Selected record slot, counted back from the newest entry.
    function automatic logic [7:0] slot(input logic [7:0] wp, input logic [7:0] back,
        input int depth);
        logic [8:0] s;
        s = {1'b0, wp} + 9'(depth) - 9'h1 - {1'b0, back};
        slot = (s >= 9'(depth)) ? 8'(s - 9'(depth)) : 8'(s);
    endfunction
    wire [7:0] f_slot = slot(fault_wp_reg, sel_idx_reg, FAULT_DEPTH);
    wire [7:0] a_slot = slot(alarm_wp_reg, sel_idx_reg, ALARM_DEPTH);
    wire [7:0] e_slot = slot(ev_wp_reg, sel_idx_reg, EVENT_DEPTH);
    logic [31:0] sel_data;
    always_comb begin
        case (sel_kind_reg)
            SEL_FAULT: sel_data = (sel_idx_reg < fault_cnt_reg) ?
                fault_mem[f_slot*4+sel_word_reg[1:0]] : 32'h0;
            SEL_ALARM: sel_data = (sel_idx_reg < alarm_cnt_reg) ?
                alarm_mem[a_slot*4+sel_word_reg[1:0]] : 32'h0;
            SEL_EVENT: sel_data = (sel_idx_reg < ev_cnt_reg) ?
                ev_mem[e_slot*2+sel_word_reg[0]] : 32'h0;
            default: sel_data = 32'h0;
        endcase
    end
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, latch_en_reg} :
        hit_status ? alarm_status :
        hit_counts ? {8'h0, ev_cnt_reg, alarm_cnt_reg, fault_cnt_reg} :
        hit_time ? ms_count_reg :
        hit_sel ? {19'h0, sel_word_reg, sel_kind_reg, sel_idx_reg} :
        hit_data ? sel_data :
        hit_tset ? ms_count_reg : UNMAPPED_VALUE;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= FAER_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            latch_en_reg <= 1'b0;
            sel_kind_reg <= SEL_FAULT;
            sel_idx_reg <= 8'h0;
            sel_word_reg <= 3'h0;
        end else begin
            case (bus_state_reg)
                FAER_IDLE: begin
                    avs_waitrequest <= 1'b1;
                    if (req) begin
                        bus_state_reg <= FAER_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rd_mux : 32'h0;
                        if (avs_write && hit_ctrl && avs_byteenable[0])
                            latch_en_reg <= avs_writedata[0];
                        if (avs_write && hit_sel) begin
                            if (avs_byteenable[0])
                                sel_idx_reg <= avs_writedata[7:0];
                            if (avs_byteenable[1]) begin
                                sel_kind_reg <= avs_writedata[9:8];
                                sel_word_reg <= avs_writedata[12:10];
                            end
                        end
                    end
                end
                FAER_ACK: begin
                    bus_state_reg <= FAER_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: bus_state_reg <= FAER_IDLE;
            endcase
        end
    end

    AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        latch_en_reg && !reset_cmd && alarm_status[AB_HW_WARN] |=> alarm_status[AB_HW_WARN])
        else $error("latched flag dropped");
    AST_LATCH_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
        latch_en_reg && reset_cmd |=> alarm_status == $past(cond_now))
        else $error("latched flags not cleared by reset");
    AST_SELF_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
        !latch_en_reg |=> alarm_status == $past(cond_now))
        else $error("status not following causes");
    AST_BRK_POS: assert property (@(posedge mclk) disable iff (!rst_n)
        (breaker_pos == 2'b11 || breaker_pos == 2'b00) |=> alarm_status[AB_BRK_POS])
        else $error("breaker position alarm missing");
    AST_HW_WARN: assert property (@(posedge mclk) disable iff (!rst_n)
        hw_problem |=> alarm_status[AB_HW_WARN])
        else $error("hw warning missing");
    AST_BRK_TIME: assert property (@(posedge mclk) disable iff (!rst_n)
        breaker_op_overtime |=> alarm_status[AB_BRK_TIME])
        else $error("breaker timing alarm missing");
    AST_FAULT_STAMP: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_stb |=> fault_mem[$past(fault_wp_reg)*4+W_TIME] == $past(ms_count_reg))
        else $error("fault record time stamp wrong");
    AST_FAULT_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_stb && fault_wp_reg == 8'(FAULT_DEPTH - 1) |=> fault_wp_reg == 8'h0)
        else $error("fault store did not wrap");
    AST_ALARM_CNT: assert property (@(posedge mclk) disable iff (!rst_n)
        alarm_cnt_reg <= 8'(ALARM_DEPTH))
        else $error("alarm count overflow");
    AST_EV_CNT: assert property (@(posedge mclk) disable iff (!rst_n)
        ev_cnt_reg <= 8'(EVENT_DEPTH) && ev_wp_reg < 8'(EVENT_DEPTH))
        else $error("event store bounds");
    AST_IN_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
        in_chg && !fault_stb |=>
        ev_mem[$past(ev_wp_reg)*2+1] == {EV_INPUT, 14'h0, 16'($past(bin_inputs))})
        else $error("input event lost");
    AST_OUT_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
        out_chg && !fault_stb && !in_chg |=>
        ev_mem[$past(ev_wp_reg)*2+1] == {EV_OUTPUT, 14'h0, 16'($past(out_contacts))})
        else $error("output event lost");
    AST_TRIP_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_stb |=> ev_mem[$past(ev_wp_reg)*2+1] ==
        {EV_TRIP, 9'h0, $past(cause_code), $past(v_a)})
        else $error("trip event wrong");
    AST_COND_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
        take_cond |=> ev_mem[$past(ev_wp_reg)*2+1] ==
        {EV_ALARM, 23'h0, $past(cond_now[chg_id]), 1'b0, $past(chg_id)})
        else $error("alarm event wrong");
    sequence s_req_wait;
        req && avs_waitrequest && bus_state_reg == FAER_IDLE;
    endsequence
    AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (!rst_n)
        s_req_wait |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing");
endmodule : faer_recorder

/* File: tb/faer_prot_model.sv */
/*
 * Behavioural model of the protection algorithm that feeds the recorder.
 * Assumes one clock shared with the recorder; the bench calls its tasks.
 */
`timescale 1ns/1ps
module faer_prot_model (
    // Clock
    input wire logic mclk,
    // Strobes and captured record fields
    output logic pass_stb,
    output logic fault_stb,
    output logic alarm_stb,
    output logic [4:0] cause_code,
    output logic [1:0] setting_group,
    output logic [3:0] phase_combo,
    output logic [15:0] v_a,
    output logic [15:0] v_b,
    output logic [15:0] v_c,
    output logic [15:0] residual_voltage
);
    initial begin
        {pass_stb, fault_stb, alarm_stb} = 3'h0;
        {cause_code, setting_group, phase_combo} = 11'h000;
        {v_a, v_b, v_c, residual_voltage} = 64'h0;
    end

    // A single-cycle pass strobe; entry waits an edge so strobes never collide.
    task automatic pulse_pass();
        @(posedge mclk);
        pass_stb <= 1'b1;
        @(posedge mclk);
        pass_stb <= 1'b0;
    endtask

    // Fields are held after the strobe, as a real algorithm keeps its last values.
    task automatic record(input bit is_fault, input logic [10:0] inf, input logic [63:0] v);
        @(posedge mclk);
        {cause_code, setting_group, phase_combo} <= inf;
        {v_a, v_b, v_c, residual_voltage} <= v;
        fault_stb <= is_fault;
        alarm_stb <= !is_fault;
        @(posedge mclk);
        fault_stb <= 1'b0;
        alarm_stb <= 1'b0;
    endtask
endmodule // faer_prot_model

/* File: tb/fault_alarm_event_recorder_tb.sv */
/*
 * Self-checking bench for the recorder: records, alarm status and events.
 * Assumes the recorder answers on Avalon-MM and runs with a short MS_DIV.
 */
`timescale 1ns/1ps
module fault_alarm_event_recorder_tb
    import faer_pkg::*;
;
    logic mclk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, alarm_status, d, r;
    logic pass_stb, fault_stb, alarm_stb, hw_problem = 1'b0, breaker_op_overtime = 1'b0;
    logic breaker_problem_in = 1'b0, aux_supply_fail = 1'b0;
    logic [4:0] cause_code;
    logic [1:0] setting_group, breaker_pos = 2'h1;
    logic [3:0] phase_combo;
    logic [15:0] v_a, v_b, v_c, residual_voltage;
    logic [18:0] stage_alarm = 19'h0;
    logic [7:0] bin_inputs = 8'h00, out_contacts = 8'h00;
    logic [63:0] vq[22];
    logic [10:0] iq[22];
    logic [31:0] seed = 32'h00002E4B;
    int failures = 0, checked = 0;

    faer_recorder #(.IN_BITS(8), .OUT_BITS(8), .MS_DIV(4)) i_faer_recorder (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pass_stb(pass_stb), .fault_stb(fault_stb), .alarm_stb(alarm_stb),
        .cause_code(cause_code), .setting_group(setting_group), .phase_combo(phase_combo),
        .v_a(v_a), .v_b(v_b), .v_c(v_c), .residual_voltage(residual_voltage),
        .stage_alarm(stage_alarm), .breaker_op_overtime(breaker_op_overtime),
        .hw_problem(hw_problem), .breaker_pos(breaker_pos),
        .breaker_problem_in(breaker_problem_in), .aux_supply_fail(aux_supply_fail),
        .bin_inputs(bin_inputs), .out_contacts(out_contacts), .alarm_status(alarm_status));

    faer_prot_model i_faer_prot_model (
        .mclk(mclk), .pass_stb(pass_stb), .fault_stb(fault_stb), .alarm_stb(alarm_stb),
        .cause_code(cause_code), .setting_group(setting_group), .phase_combo(phase_combo),
        .v_a(v_a), .v_b(v_b), .v_c(v_c), .residual_voltage(residual_voltage));

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected status vector built from the level inputs.
    function logic [31:0] exp_status(input logic [31:0] v);
        return {7'h00, v[23], 1'b0, v[20], v[22:21] == 2'h0 || v[22:21] == 2'h3, v[19],
            v[18:0], v[24]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low; entry waits an edge first.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        int n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 100) begin
            failures++;
            report_and_stop();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd_rec(input logic [1:0] k, input logic [7:0] idx, input logic [1:0] w,
            output logic [31:0] q);
        bus(1'b1, A_SEL, {19'h0, 1'b0, w, k, idx}, q);
        bus(1'b0, A_DATA, 32'h0, q);
    endtask

    task automatic step_in(input logic [7:0] v);
        @(posedge mclk);
        bin_inputs <= v;
        i_faer_prot_model.pulse_pass();
        repeat (2) @(posedge mclk);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        check(alarm_status, 32'h0);
        bus(1'b0, 12'hFFC, 32'h0, d);
        check(d, UNMAPPED_VALUE);
        // Fill the log past its depth with input changes.
        for (int i = 1; i <= 205; i++) step_in(i[7:0]);
        rd_rec(SEL_EVENT, 8'd0, W_INFO, d);
        check({22'h0, d[31:30], d[7:0]}, {22'h0, EV_INPUT, 8'hCD});
        rd_rec(SEL_EVENT, 8'd199, W_INFO, d);
        check({22'h0, d[31:30], d[7:0]}, {22'h0, EV_INPUT, 8'h06});
        rd_rec(SEL_EVENT, 8'd200, W_INFO, d);
        check(d, 32'h0);
        @(posedge mclk);
        out_contacts <= 8'h5A;
        i_faer_prot_model.pulse_pass();
        settle();
        rd_rec(SEL_EVENT, 8'd0, W_INFO, d);
        check({22'h0, d[31:30], d[7:0]}, {22'h0, EV_OUTPUT, 8'h5A});
        // Supply failure raised then dropped, with latching off.
        for (int i = 1; i >= 0; i--) begin
            @(posedge mclk);
            aux_supply_fail <= i[0];
            i_faer_prot_model.pulse_pass();
            settle();
            check({31'h0, alarm_status[AB_AUX_FAIL]}, {31'h0, i[0]});
            rd_rec(SEL_EVENT, 8'd0, W_INFO, d);
            check({23'h0, d[31:30], d[6:0]}, {23'h0, EV_ALARM, i[0], 6'h00});
        end
        // Random level mixes; the breaker position takes all four codes.
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            r[22:21] = i[1:0];
            r[24] = 1'b0;
            @(posedge mclk);
            {breaker_problem_in, breaker_pos, breaker_op_overtime, hw_problem} <= r[23:19];
            stage_alarm <= r[18:0];
            settle();
            check(alarm_status, exp_status(r));
        end
        @(posedge mclk);
        {breaker_problem_in, breaker_pos, breaker_op_overtime, hw_problem} <= 5'h08;
        stage_alarm <= 19'h0;
        bus(1'b1, A_CTRL, 32'h00000001, d);
        @(posedge mclk);
        hw_problem <= 1'b1;
        settle();
        @(posedge mclk);
        hw_problem <= 1'b0;
        settle();
        check(alarm_status, 32'h00100000);
        bus(1'b1, A_CTRL, 32'h00000003, d);
        settle();
        check(alarm_status, 32'h0);
        bus(1'b1, A_CTRL, 32'h00000000, d);
        bus(1'b1, A_TIME_SET, 32'h00001000, d);
        for (int i = 0; i < 22; i++) begin
            vq[i] = {rnd(), rnd()};
            iq[i] = 11'(rnd());
            i_faer_prot_model.record(1'b1, iq[i], vq[i]);
        end
        settle();
        rd_rec(SEL_EVENT, 8'd0, W_INFO, d);
        check({30'h0, d[31:30]}, {30'h0, EV_TRIP});
        rd_rec(SEL_FAULT, 8'd0, W_VAB, d);
        check(d, vq[21][63:32]);
        rd_rec(SEL_FAULT, 8'd0, W_VCN, d);
        check(d, vq[21][31:0]);
        rd_rec(SEL_FAULT, 8'd0, W_INFO, d);
        check(d & 32'h00007FF0, {17'h0, iq[21], 4'h0});
        rd_rec(SEL_FAULT, 8'd0, W_TIME, d);
        check({31'h0, d >= 32'h00001000 && d < 32'h00001100}, 32'h1);
        rd_rec(SEL_FAULT, 8'd19, W_VAB, d);
        check(d, vq[2][63:32]);
        rd_rec(SEL_FAULT, 8'd20, W_VAB, d);
        check(d, 32'h0);
        for (int i = 0; i < 6; i++) begin
            vq[i] = {rnd(), rnd()};
            iq[i] = 11'(rnd());
            i_faer_prot_model.record(1'b0, iq[i], vq[i]);
        end
        settle();
        rd_rec(SEL_ALARM, 8'd0, W_INFO, d);
        check(d & 32'h00007FF0, {17'h0, iq[5], 4'h0});
        rd_rec(SEL_ALARM, 8'd4, W_VCN, d);
        check(d, vq[1][31:0]);
        rd_rec(SEL_ALARM, 8'd5, W_VCN, d);
        check(d, 32'h0);
        bus(1'b0, A_COUNTS, 32'h0, d);
        check(d, {8'h0, 8'(EVENT_DEPTH), 8'(ALARM_DEPTH), 8'(FAULT_DEPTH)});
        report_and_stop();
    end
endmodule // fault_alarm_event_recorder_tb
